//--- rtl/acs_result_mem.sv
// result memory: one row per channel holding scaled data and its sign and overrange flags
// assumes one writer (the sequencer) and a read address that may change every cycle
`timescale 1ns/10ps

module acs_result_mem #(
    parameter int DW  = 18,
    parameter int NCH = 2,
    parameter int AW  = 1
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // read port, data one cycle after the address
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [NCH];

    // rows reset to zero so a read before the first conversion is defined
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NCH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // registered read keeps the bus answer off a long combinational path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (32'(raddr_i) < NCH) begin
            rdata_o <= mem_q[raddr_i];
        end else begin
            rdata_o <= '0;
        end
    end

endmodule : acs_result_mem

//--- rtl/acs_sequencer.sv
// conversion sequencer of a two-channel sigma-delta converter, with its package
// assumes a classic wishbone master and a filter that presents a settled result
// What this block does
// - chopped: settle 43/44, sample, settle 42, sample, scale 163
// - unchopped: settle 43/44, one sample, scale 163
// - chopped result averages normal and swapped samples
// - scaling averages, applies gain, stores channel data
// - sampling length follows channel filter word
// - done output high at scaling start
// - cycle end sets that channel's done flag, done low
// - continuous mode moves straight to next channel
// - each channel keeps own time and chop
// - saturate set clamps out-of-range data
// - saturate clear keeps wrapped data plus flags
// - overrange flag derived from conversion result
// - bipolar coding centred on 8000, wraps outside
// - unipolar coding from 0000, negative gives zero
// - mode write clears done flags, done output high
// - unread result overwritten, flag dropped, done high
// - done select: any channel or all enabled
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps

// ****************************************************************
// package
// ****************************************************************
package acs_pkg;
    // register byte offsets
    localparam logic [7:0] MODE_OFS    = 8'h00;
    localparam logic [7:0] IOCTL_OFS   = 8'h04;
    localparam logic [7:0] CSTAT_OFS   = 8'h08;
    localparam logic [7:0] IRQST_OFS   = 8'h0C;
    localparam logic [7:0] IRQMK_OFS   = 8'h10;
    localparam logic [3:0] CH_BASE_ROW = 4'h2;  // channel block n at 0x20 + 0x10*n
    localparam logic [3:0] CTIME_SUB   = 4'h0;
    localparam logic [3:0] CHST_SUB    = 4'h4;
    localparam logic [3:0] DATA_SUB    = 4'h8;
    localparam logic [3:0] GAIN_SUB    = 4'hC;
    // mode register fields
    localparam int MODE_RUN_LSB = 0;  // 2 bits
    localparam int MODE_SAT_BIT = 2;
    localparam int MODE_BIP_BIT = 3;
    localparam int MODE_CH_LSB  = 4;
    localparam logic [1:0] RUN_IDLE   = 2'h0;
    localparam logic [1:0] RUN_SINGLE = 2'h1;
    localparam logic [1:0] RUN_CONT   = 2'h2;
    // conversion time register fields
    localparam int CT_FW_LSB   = 0;   // 7 bits
    localparam int CT_CHOP_BIT = 7;
    localparam int CT_EN_BIT   = 8;
    localparam logic [8:0] CT_RESET   = 9'h1FF;
    localparam logic [15:0] GAIN_UNITY = 16'h8000;
    localparam int GAIN_SHIFT = 15;
    // phase lengths in master clock cycles
    localparam logic [15:0] SETTLE_LONG  = 16'h002C;  // 44
    localparam logic [15:0] SETTLE_SHORT = 16'h002B;  // 43
    localparam logic [15:0] SETTLE_CHOP  = 16'h002A;  // 42
    localparam logic [15:0] SCALE_LEN    = 16'h00A3;  // 163
    // output code points
    localparam logic [16:0] BIP_ZERO = 17'h08000;
    localparam logic [15:0] CODE_MIN = 16'h0000;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE_A, ST_SAMPLE_A, ST_SETTLE_B, ST_SAMPLE_B, ST_SCALE
    } acs_phase_e;
endpackage : acs_pkg

// ****************************************************************
// sequencer
// ****************************************************************
module acs_sequencer #(
    parameter int NCH         = 2,
    parameter int CW          = 1,
    parameter int SAMPLE_UNIT = 64   // cycles per filter word step
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // converter front end
    input  wire logic [23:0]   filt_result_i,
    output logic      [CW-1:0] mux_chan_o,
    output logic               mux_swap_o,
    output logic               mod_run_o,
    // status pins
    output logic               done_n_o,
    output logic               irq_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    acs_pkg::acs_phase_e phase_q;
    logic [15:0]   cnt_q;
    logic [CW-1:0] chan_q;
    logic [1:0]    run_q;
    logic          sat_q, bip_q, done_output_select_q, pend_q;
    logic [CW-1:0] start_ch_q;
    logic [8:0]    ctime_q [NCH];
    logic [15:0]   gain_q  [NCH];
    logic [NCH-1:0]   ready_q;
    logic [2*NCH-1:0] irq_st_q, irq_mk_q;
    logic [23:0]   samp_a_q, samp_b_q;
    logic [17:0]   mem_rd;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    wire           acc      = pend_q & wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire           wr       = acc & wb_we_i;
    wire           rd       = acc & ~wb_we_i;
    wire [15:0]    wmask    = lane_mask(wb_sel_i);
    wire [15:0]    wdat     = wb_dat_i[15:0];
    wire [3:0]     row      = wb_adr_i[7:4];
    wire [3:0]     sub      = wb_adr_i[3:0];
    wire [3:0]     row_off  = row - acs_pkg::CH_BASE_ROW;
    wire [CW-1:0]  ch_sel   = row_off[CW-1:0];
    wire           ch_hit   = row >= acs_pkg::CH_BASE_ROW && 32'(row_off) < NCH;
    wire           wr_mode  = wr & (wb_adr_i == acs_pkg::MODE_OFS);
    wire           rd_irqst = rd & (wb_adr_i == acs_pkg::IRQST_OFS);
    wire           rd_data  = rd & ch_hit & (sub == acs_pkg::DATA_SUB);
    wire [15:0]    mode_new = (16'({start_ch_q, bip_q, sat_q, run_q}) & ~wmask) | (wdat & wmask);

    // ****************************************************************
    // channel helpers
    // ****************************************************************
    logic [NCH-1:0] en;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_en
            assign en[g] = ctime_q[g][acs_pkg::CT_EN_BIT];
        end
    endgenerate

    // next enabled channel above cur, wrapping to the lowest
    function automatic logic [CW-1:0] next_ch(input logic [CW-1:0] cur,
                                              input logic [NCH-1:0] ena);
        next_ch = cur;
        for (int k = NCH; k >= 1; k--) begin
            if (ena[(32'(cur) + k) % NCH]) begin
                next_ch = CW'((32'(cur) + k) % NCH);
            end
        end
    endfunction : next_ch

    wire [8:0]  ct_cur   = ctime_q[chan_q];
    wire        chop     = ct_cur[acs_pkg::CT_CHOP_BIT];
    wire [6:0]  fw       = ct_cur[acs_pkg::CT_FW_LSB +: 7];
    wire [15:0] samp_len = 16'(((fw == 7'h00) ? 7'h01 : fw) * SAMPLE_UNIT);
    wire        tick     = cnt_q == 16'h0000;

    // ****************************************************************
    // scaling datapath
    // ****************************************************************
    wire signed [24:0] diff   = $signed({samp_a_q[23], samp_a_q}) - $signed({samp_b_q[23], samp_b_q});
    wire signed [24:0] avg    = chop ? (diff >>> 1) : $signed({samp_a_q[23], samp_a_q});
    wire signed [41:0] prod   = avg * $signed({1'b0, gain_q[chan_q]});
    wire signed [25:0] q      = 26'(prod >>> acs_pkg::GAIN_SHIFT);
    wire signed [25:0] code   = bip_q ? q + $signed(26'(acs_pkg::BIP_ZERO)) : q;
    wire               sign   = q[25];
    wire               over   = code[25] | (code[24:16] != 9'h000);
    wire [15:0]        wrap   = (!bip_q && sign) ? acs_pkg::CODE_MIN : code[15:0];
    wire [15:0]        clamp  = code[25] ? acs_pkg::CODE_MIN : acs_pkg::CODE_MAX;
    wire [15:0]        result = (sat_q && over) ? clamp : wrap;
    wire               fin    = phase_q == acs_pkg::ST_SCALE && tick;
    wire               scale_in = (phase_q == acs_pkg::ST_SAMPLE_B ||
                                   (phase_q == acs_pkg::ST_SAMPLE_A && !chop)) && tick;
    wire               lost   = scale_in & ready_q[chan_q];
    wire               go_on  = run_q == acs_pkg::RUN_CONT && en != '0;

    acs_result_mem #(.DW(18), .NCH(NCH), .AW(CW)) u_mem (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (fin),
        .waddr_i (chan_q),
        .wdata_i ({over, sign, result}),
        .raddr_i (ch_sel),
        .rdata_o (mem_rd)
    );

    // ****************************************************************
    // phase sequencer
    // ****************************************************************
    // a mode write restarts the cycle from a long settle, or goes to idle when the new run mode is idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= acs_pkg::ST_IDLE;
            cnt_q   <= 16'h0000;
            chan_q  <= '0;
        end else if (wr_mode) begin
            chan_q  <= mode_new[acs_pkg::MODE_CH_LSB +: CW];
            cnt_q   <= acs_pkg::SETTLE_LONG - 16'h0001;
            phase_q <= (mode_new[1:0] == acs_pkg::RUN_IDLE) ? acs_pkg::ST_IDLE
                                                            : acs_pkg::ST_SETTLE_A;
        end else if (!tick) begin
            cnt_q <= cnt_q - 16'h0001;
        end else begin
            case (phase_q)
                acs_pkg::ST_SETTLE_A: begin
                    phase_q <= acs_pkg::ST_SAMPLE_A;
                    cnt_q   <= samp_len - 16'h0001;
                end
                acs_pkg::ST_SAMPLE_A: begin
                    phase_q <= chop ? acs_pkg::ST_SETTLE_B : acs_pkg::ST_SCALE;
                    cnt_q   <= (chop ? acs_pkg::SETTLE_CHOP : acs_pkg::SCALE_LEN) - 16'h0001;
                end
                acs_pkg::ST_SETTLE_B: begin
                    phase_q <= acs_pkg::ST_SAMPLE_B;
                    cnt_q   <= samp_len - 16'h0001;
                end
                acs_pkg::ST_SAMPLE_B: begin
                    phase_q <= acs_pkg::ST_SCALE;
                    cnt_q   <= acs_pkg::SCALE_LEN - 16'h0001;
                end
                acs_pkg::ST_SCALE: begin
                    phase_q <= go_on ? acs_pkg::ST_SETTLE_A : acs_pkg::ST_IDLE;
                    cnt_q   <= acs_pkg::SETTLE_SHORT - 16'h0001;
                    chan_q  <= go_on ? next_ch(chan_q, en) : chan_q;
                end
                default: begin
                    phase_q <= acs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // filter results captured on the last cycle of each sampling period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            samp_a_q <= 24'h000000;
            samp_b_q <= 24'h000000;
        end else if (tick && phase_q == acs_pkg::ST_SAMPLE_A) begin
            samp_a_q <= filt_result_i;
        end else if (tick && phase_q == acs_pkg::ST_SAMPLE_B) begin
            samp_b_q <= filt_result_i;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // mode register; a single conversion falls back to idle when it ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {start_ch_q, bip_q, sat_q, run_q} <= '0;
            done_output_select_q <= 1'b0;
            irq_mk_q <= '0;
        end else begin
            if (wr_mode) begin
                run_q      <= mode_new[acs_pkg::MODE_RUN_LSB +: 2];
                sat_q      <= mode_new[acs_pkg::MODE_SAT_BIT];
                bip_q      <= mode_new[acs_pkg::MODE_BIP_BIT];
                start_ch_q <= mode_new[acs_pkg::MODE_CH_LSB +: CW];
            end else if (fin && run_q == acs_pkg::RUN_SINGLE) begin
                run_q <= acs_pkg::RUN_IDLE;
            end
            if (wr && wb_adr_i == acs_pkg::IOCTL_OFS && wb_sel_i[0]) begin
                done_output_select_q <= wdat[0];
            end
            if (wr && wb_adr_i == acs_pkg::IRQMK_OFS) begin
                irq_mk_q <= (irq_mk_q & ~wmask[2*NCH-1:0]) | (wdat[2*NCH-1:0] & wmask[2*NCH-1:0]);
            end
        end
    end

    // per-channel time, chop, enable and gain
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire hit = wr && ch_hit && 32'(ch_sel) == g;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctime_q[g] <= acs_pkg::CT_RESET;
                    gain_q[g]  <= acs_pkg::GAIN_UNITY;
                end else if (hit && sub == acs_pkg::CTIME_SUB) begin
                    ctime_q[g] <= (ctime_q[g] & ~wmask[8:0]) | (wdat[8:0] & wmask[8:0]);
                end else if (hit && sub == acs_pkg::GAIN_SUB) begin
                    gain_q[g] <= (gain_q[g] & ~wmask) | (wdat & wmask);
                end
            end
        end
    endgenerate

    // done flags: completion sets, data read or mode write clears, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_q <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (fin && 32'(chan_q) == i) begin
                    ready_q[i] <= 1'b1;
                end else if (wr_mode || (lost && 32'(chan_q) == i)) begin
                    ready_q[i] <= 1'b0;
                end else if (rd_data && 32'(ch_sel) == i) begin
                    ready_q[i] <= 1'b0;
                end
            end
        end
    end

    // sticky events: low half completions, high half overwritten results
    wire [2*NCH-1:0] irq_set = {(lost ? NCH'(1) << chan_q : NCH'(0)),
                                (fin  ? NCH'(1) << chan_q : NCH'(0))};
    wire [2*NCH-1:0] irq_nxt = (rd_irqst ? '0 : irq_st_q) | irq_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q <= '0;
            irq_o    <= 1'b0;
        end else begin
            irq_st_q <= irq_nxt;
            irq_o    <= |(irq_nxt & irq_mk_q);
        end
    end

    // ****************************************************************
    // done pin and front end outputs
    // ****************************************************************
    // finishing channel counted early, so done goes low on the edge that sets its flag, not one cycle later
    wire [NCH-1:0] rdy_fin = ready_q | (fin ? NCH'(1) << chan_q : NCH'(0));
    wire any_rdy = |rdy_fin;
    wire all_rdy = (en != '0) && ((rdy_fin | ~en) == '1);
    wire rdy_sel = done_output_select_q ? all_rdy : any_rdy;
    // forced high through the whole scaling phase, so a lost result shows 163 cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_n_o   <= 1'b1;
            mux_chan_o <= '0;
            mux_swap_o <= 1'b0;
            mod_run_o  <= 1'b0;
        end else begin
            done_n_o   <= wr_mode | scale_in | (phase_q == acs_pkg::ST_SCALE && !fin) |
                          !rdy_sel;
            mux_chan_o <= chan_q;
            mux_swap_o <= phase_q == acs_pkg::ST_SETTLE_B || phase_q == acs_pkg::ST_SAMPLE_B;
            mod_run_o  <= phase_q == acs_pkg::ST_SAMPLE_A || phase_q == acs_pkg::ST_SAMPLE_B;
        end
    end

    // ****************************************************************
    // bus answer
    // ****************************************************************
    logic [31:0] rdat;
    always_comb begin
        rdat = 32'h00000000;
        if (wb_adr_i == acs_pkg::MODE_OFS) begin
            rdat = 32'({start_ch_q, bip_q, sat_q, run_q});
        end else if (wb_adr_i == acs_pkg::IOCTL_OFS) begin
            rdat = 32'(done_output_select_q);
        end else if (wb_adr_i == acs_pkg::CSTAT_OFS) begin
            rdat = 32'({phase_q, 8'(ready_q)});  // phase in [10:8], done flags from bit 0
        end else if (wb_adr_i == acs_pkg::IRQST_OFS) begin
            rdat = 32'(irq_st_q);
        end else if (wb_adr_i == acs_pkg::IRQMK_OFS) begin
            rdat = 32'(irq_mk_q);
        end else if (ch_hit && sub == acs_pkg::CTIME_SUB) begin
            rdat = 32'(ctime_q[ch_sel]);
        end else if (ch_hit && sub == acs_pkg::CHST_SUB) begin
            rdat = {24'h000000, 4'(ch_sel), 1'b0, mem_rd[17:16], ready_q[ch_sel]};
        end else if (ch_hit && sub == acs_pkg::DATA_SUB) begin
            rdat = {16'h0000, mem_rd[15:0]};
        end else if (ch_hit && sub == acs_pkg::GAIN_SUB) begin
            rdat = {16'h0000, gain_q[ch_sel]};
        end
    end

    // two-cycle answer: first cycle fetches the result row, second acks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q   <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            pend_q   <= wb_cyc_i & wb_stb_i & ~pend_q & ~wb_ack_o;
            wb_ack_o <= acc;
            wb_dat_o <= rd ? rdat : 32'h00000000;
        end
    end

endmodule : acs_sequencer

//--- verification/acs_filter_model.sv
// filter front end model: presents one settled result per channel
// assumes mux outputs of the sequencer drive it directly
`timescale 1ns/10ps

module acs_filter_model (
    // sequencer side
    input  wire logic [0:0]  mux_chan_i,
    input  wire logic        mux_swap_i,
    input  wire logic        mod_run_i,
    // per channel input level
    input  wire logic [23:0] lvl0_i,
    input  wire logic [23:0] lvl1_i,
    output logic      [23:0] filt_result_o
);
    logic [23:0] lvl_w;

    // outside sampling show junk so stale values never pass
    assign lvl_w         = mux_chan_i[0] ? lvl1_i : lvl0_i;
    assign filt_result_o = !mod_run_i ? ~lvl_w : (mux_swap_i ? -lvl_w : lvl_w);
endmodule : acs_filter_model

//--- verification/acs_sequencer_assertions.sv
// checker for the sequencer pins: bus handshake and conversion timing
// assumes a single clock domain with synchronous reset
`timescale 1ns/10ps

module acs_seq_checker (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // converter pins
    input  wire logic [0:0]  mux_chan_o,
    input  wire logic        mux_swap_o,
    input  wire logic        mod_run_o,
    input  wire logic        done_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] low_q;

    // cycles since sampling stopped, saturating so idle never wraps
    always_ff @(posedge clk_i) begin
        if (rst_i || mod_run_o) low_q <= rst_i ? 8'hFF : 8'h00;
        else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
    end

    sequence mode_wr_s;
        wb_ack_o && wb_we_i && wb_adr_i == acs_pkg::MODE_OFS;
    endsequence

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
        else $error("ack late");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    mode_done_high_a: assert property (mode_wr_s |=> ##[0:1] done_n_o)
        else $error("mode write kept done low");
    scale_done_high_a: assert property ($fell(mod_run_o) && !mux_swap_o |-> done_n_o [*8])
        else $error("done low in scaling");
    scale_length_a: assert property ($fell(done_n_o) |-> low_q >= 8'hA0)
        else $error("scaling too short");
    settle_gap_a: assert property ($rose(mod_run_o) |-> low_q >= 8'h29)
        else $error("settling too short");
    swap_settle_a: assert property ($rose(mux_swap_o) |-> !mod_run_o [*8])
        else $error("no settle before chopped sample");
    chan_hold_a: assert property (mod_run_o && $past(mod_run_o) |-> $stable(mux_chan_o))
        else $error("channel moved while sampling");
endmodule : acs_seq_checker

//--- verification/test_adc_conversion_sequencer.sv
// top testbench: wishbone tasks drive conversions and check results
// assumes the filter model on the front end and the checker bound below
`timescale 1ns/10ps

module test_adc_conversion_sequencer;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic [23:0] filt_result_i;
    logic [23:0] lvl0     = 24'h0;
    logic [23:0] lvl1     = 24'h0;
    logic [0:0]  mux_chan_o;
    logic        wb_ack_o, mux_swap_o, mod_run_o, done_n_o, irq_o;
    int          error_cnt, total_checks, cyc_cnt;

    // ****************************************************************
    // design and front end
    // ****************************************************************
    acs_sequencer #(.NCH(2), .CW(1), .SAMPLE_UNIT(1)) u_acs_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .filt_result_i(filt_result_i),
        .mux_chan_o(mux_chan_o), .mux_swap_o(mux_swap_o), .mod_run_o(mod_run_o),
        .done_n_o(done_n_o), .irq_o(irq_o));
    acs_filter_model u_acs_filter_model (.mux_chan_i(mux_chan_o), .mux_swap_i(mux_swap_o),
        .mod_run_i(mod_run_o), .lvl0_i(lvl0), .lvl1_i(lvl1), .filt_result_o(filt_result_i));

    // 25 ns clock and hang guard
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            close_out();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic fail(input string msg);
        error_cnt++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask : cmp_bit

    // one classic cycle, held until ack, then one idle cycle
    task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) fail("no ack");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb_rw

    task automatic wait_done();
        int n;
        n = 0;
        while (done_n_o !== 1'b0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 1000) fail("no conversion done");
    endtask : wait_done

    // single conversion on channel 0 and full readback
    task automatic run_row(input logic [7:0] mode, input logic [23:0] lvl,
            input logic [15:0] exp_d, input logic [2:0] exp_s, input logic [2:0] msk);
        lvl0 <= lvl;
        wb_rw(1'b1, acs_pkg::MODE_OFS, {24'h0, mode});
        wait_done();
        cmp_bit(irq_o, 1'b1, "irq not raised");
        wb_rw(1'b0, acs_pkg::CSTAT_OFS, 32'h0);
        cmp_word(rd & 32'h3, 32'h1, "converter done flag");
        wb_rw(1'b0, 8'h24, 32'h0);
        cmp_word(rd & {29'h0, msk}, {29'h0, exp_s & msk}, "channel flags");
        wb_rw(1'b0, 8'h28, 32'h0);
        cmp_word(rd & 32'hFFFF, {16'h0, exp_d}, "channel data");
        cmp_bit(done_n_o, 1'b1, "done stays low after read");
        wb_rw(1'b0, acs_pkg::IRQST_OFS, 32'h0);
        cmp_word(rd & 32'h3, 32'h1, "done event");
        cmp_bit(irq_o, 1'b0, "irq not cleared");
    endtask : run_row

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cmp_bit(done_n_o, 1'b1, "done low after reset");
        wb_rw(1'b0, 8'h20, 32'h0);
        cmp_word(rd, 32'h1FF, "conv time reset");
        wb_rw(1'b0, 8'h2C, 32'h0);
        cmp_word(rd, 32'h8000, "gain reset");
        wb_rw(1'b0, 8'hF0, 32'h0);
        cmp_word(rd, 32'h0, "unmapped read");
        // chopped, short filter word, channel 1 off
        wb_rw(1'b1, 8'h20, 32'h184);
        wb_rw(1'b1, 8'h30, 32'h000);
        wb_rw(1'b1, acs_pkg::IRQMK_OFS, 32'h1);
        run_row(8'h09, 24'h000100, 16'h8100, 3'b001, 3'b111);
        run_row(8'h09, 24'hFFFFFF, 16'h7FFF, 3'b011, 3'b111);
        run_row(8'h09, 24'h008000, 16'h0000, 3'b101, 3'b111);
        run_row(8'h0D, 24'h008000, 16'hFFFF, 3'b001, 3'b001);
        run_row(8'h0D, 24'hFF7FFF, 16'h0000, 3'b001, 3'b001);
        run_row(8'h01, 24'h001234, 16'h1234, 3'b001, 3'b111);
        run_row(8'h01, 24'hFFFFFB, 16'h0000, 3'b111, 3'b111);
        run_row(8'h01, 24'h010001, 16'h0001, 3'b101, 3'b111);
        // unchopped single sample
        wb_rw(1'b1, 8'h20, 32'h104);
        run_row(8'h09, 24'h000200, 16'h8200, 3'b001, 3'b111);
        // continuous over both channels, done only when all unread
        lvl1 <= 24'h000300;
        wb_rw(1'b1, 8'h30, 32'h102);
        wb_rw(1'b1, acs_pkg::IOCTL_OFS, 32'h1);
        wb_rw(1'b1, acs_pkg::MODE_OFS, 32'h0A);
        wait_done();
        wb_rw(1'b0, acs_pkg::CSTAT_OFS, 32'h0);
        cmp_word(rd & 32'h3, 32'h3, "both channels done");
        wb_rw(1'b0, 8'h38, 32'h0);
        cmp_word(rd & 32'hFFFF, 32'h8300, "channel 1 data");
        wb_rw(1'b1, acs_pkg::MODE_OFS, 32'h00);
        cmp_bit(done_n_o, 1'b1, "done low after mode write");
        close_out();
    end
endmodule : test_adc_conversion_sequencer

bind acs_sequencer acs_seq_checker u_acs_seq_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mux_chan_o(mux_chan_o), .mux_swap_o(mux_swap_o), .mod_run_o(mod_run_o),
    .done_n_o(done_n_o));
